// ==== rtl/pdl_pkg.sv ====
package pdl_pkg;

    // Clock and cable test timing.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DIAG_TEST_TIME_NS = 10000;
    localparam int unsigned DIAG_TEST_CYCLES =
        (DIAG_TEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIAG_CNT_W = 10;
    localparam logic [DIAG_CNT_W-1:0] DIAG_CNT_ZERO = 10'h000;
    localparam logic [DIAG_CNT_W-1:0] DIAG_CNT_LAST = DIAG_CNT_W'(DIAG_TEST_CYCLES - 1);

    // Wishbone geometry: byte address is four times the register index.
    localparam int ADR_W = 18;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int PORT_W = 4;
    localparam int IDX_W = 12;
    localparam logic [PORT_W-1:0] PORT_NUM_DEFAULT = 4'h1;

    // Register indices within one port's block.
    localparam logic [IDX_W-1:0] IDX_CABLE_DIAG = 12'h124;
    localparam logic [IDX_W-1:0] IDX_LINK_STATUS = 12'h126;
    localparam logic [IDX_W-1:0] IDX_RX_SYM_ERR_CNT = 12'h12a;
    localparam logic [IDX_W-1:0] IDX_EVENT_ENABLE_FLAGS = 12'h136;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h140;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h141;

    // Field positions.
    localparam int DIAG_START_BIT = 15;
    localparam int DIAG_RSV_HI_BIT = 14;
    localparam int DIAG_PAIR_LSB = 12;
    localparam int DIAG_RSV_LO_LSB = 10;
    localparam int DIAG_RESULT_LSB = 8;
    localparam int LINK_1000_BIT = 1;
    localparam int LINK_100_BIT = 0;
    localparam int ENABLE_LSB = 8;
    localparam int FLAG_LSB = 0;
    localparam int NUM_EVENTS = 8;
    localparam int NUM_IRQ = 3;
    localparam int IRQ_DIAG_DONE = 0;
    localparam int IRQ_PORT_EVENT = 1;
    localparam int IRQ_ERR_CNT_FULL = 2;

    // Cable result codes.
    localparam logic [1:0] CABLE_NO_FAULT = 2'h0;
    localparam logic [1:0] CABLE_OPEN = 2'h1;
    localparam logic [1:0] CABLE_SHORT = 2'h2;

    // Reset values.
    localparam logic [15:0] ERR_CNT_RESET = 16'h0000;
    localparam logic [15:0] ERR_CNT_MAX = 16'hffff;
    localparam logic [15:0] ERR_CNT_ONE = 16'h0001;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [1:0] FIELD2_RESET = 2'h0;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic {DIAG_IDLE, DIAG_RUN} pdl_diag_state_t;

    typedef struct packed {
        pdl_diag_state_t state;
        logic [DIAG_CNT_W-1:0] cnt;
        logic busy;
        logic done;
        logic [1:0] result;
    } pdl_tester_t;

endpackage

// ==== rtl/pdl_cable_tester.sv ====
`timescale 1ns/10ps
`default_nettype none

// Runs one timed cable test on the selected pair and latches its verdict.
module pdl_cable_tester (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [1:0] pair,
    input wire logic [3:0] pair_open,
    input wire logic [3:0] pair_short,
    output logic busy,
    output logic done,
    output logic [1:0] result
);
    pdl_pkg::pdl_tester_t s_reg;
    pdl_pkg::pdl_tester_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        case (s_reg.state)
            pdl_pkg::DIAG_IDLE:
            begin
                if (start)
                begin
                    s_next.state = pdl_pkg::DIAG_RUN;
                    s_next.cnt = pdl_pkg::DIAG_CNT_ZERO;
                    s_next.busy = 1'b1;
                end
            end
            pdl_pkg::DIAG_RUN:
            begin
                // An abort leaves the previous verdict in place and raises no done.
                if (abort)
                begin
                    s_next.state = pdl_pkg::DIAG_IDLE;
                    s_next.busy = 1'b0;
                end
                else if (s_reg.cnt == pdl_pkg::DIAG_CNT_LAST)
                begin
                    // A short outranks an open when both comparators fire.
                    if (pair_short[pair])
                        s_next.result = pdl_pkg::CABLE_SHORT;
                    else if (pair_open[pair])
                        s_next.result = pdl_pkg::CABLE_OPEN;
                    else
                        s_next.result = pdl_pkg::CABLE_NO_FAULT;
                    s_next.state = pdl_pkg::DIAG_IDLE;
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                end
                else
                begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
            default:
            begin
                s_next.state = pdl_pkg::DIAG_IDLE;
                s_next.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_reg.state <= pdl_pkg::DIAG_IDLE;
            s_reg.cnt <= pdl_pkg::DIAG_CNT_ZERO;
            s_reg.busy <= 1'b0;
            s_reg.done <= 1'b0;
            s_reg.result <= pdl_pkg::CABLE_NO_FAULT;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign busy = s_reg.busy;
    assign done = s_reg.done;
    assign result = s_reg.result;

endmodule

`default_nettype wire

// ==== rtl/pdl_regs.sv ====
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Writing one to start runs a pair test, then the start bit self-clears.
// - Writing zero to the start bit stops a running cable test.
// - Start bit reads one while testing, zero once the test is over.
// - Pair select 00, 01, 10, 11 tests pair A, B, C, D.
// - Result field: 00 no fault, 01 open, 10 short, 11 reserved.
// - Link status bit 1 is gigabit link, bit 0 is 100 Mb link.
// - Sixteen-bit count of frames with symbol errors, reset zero, cleared by read.
// - Flags 7..0: jabber, rx error, page, parallel fault, ack, down, remote, up.
// - Enables 15..8 gate the same events, all disabled after reset.
module pdl_regs #(
    parameter logic [pdl_pkg::PORT_W-1:0] PORT_NUM = pdl_pkg::PORT_NUM_DEFAULT
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [pdl_pkg::ADR_W-1:0] ADR_I,
    input wire logic [pdl_pkg::DAT_W-1:0] DAT_I,
    output logic [pdl_pkg::DAT_W-1:0] DAT_O,
    input wire logic WE_I,
    input wire logic [pdl_pkg::SEL_W-1:0] SEL_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    output logic ACK_O,
    input wire logic LINK_UP_1000,
    input wire logic LINK_UP_100,
    input wire logic RX_SYMBOL_ERROR_FRAME,
    input wire logic [pdl_pkg::NUM_EVENTS-1:0] PORT_EVENTS,
    input wire logic [3:0] PAIR_OPEN,
    input wire logic [3:0] PAIR_SHORT,
    output logic DIAG_ACTIVE,
    output logic [1:0] DIAG_PAIR,
    output logic PORT_IRQ,
    output logic IRQ
);
    typedef struct packed {
        logic ack;
        logic [pdl_pkg::DAT_W-1:0] rdata;
        logic diag_start;
        logic diag_abort;
        logic diag_rsv_hi;
        logic [1:0] diag_pair;
        logic [1:0] diag_rsv_lo;
        logic [pdl_pkg::NUM_EVENTS-1:0] flags;
        logic [pdl_pkg::NUM_EVENTS-1:0] enables;
        logic [15:0] err_cnt;
        logic [pdl_pkg::NUM_IRQ-1:0] irq_status;
        logic [pdl_pkg::NUM_IRQ-1:0] irq_mask;
        logic port_irq;
        logic irq;
    } pdl_regs_state_t;

    pdl_regs_state_t s_reg;
    pdl_regs_state_t s_next;

    logic access;
    logic wr;
    logic rd;
    logic port_hit;
    logic [pdl_pkg::IDX_W-1:0] idx;
    logic diag_busy;
    logic diag_done;
    logic [1:0] diag_result;
    logic flags_rd_clr;
    logic [pdl_pkg::NUM_EVENTS-1:0] flags_nxt;

    // A new request is taken only when no answer is pending, so ack is one cycle.
    assign access = CYC_I & STB_I & ~s_reg.ack;
    assign wr = access & WE_I;
    assign rd = access & ~WE_I;
    assign port_hit = (ADR_I[pdl_pkg::ADR_W-1 -: pdl_pkg::PORT_W] == PORT_NUM);
    assign idx = ADR_I[pdl_pkg::IDX_W+1:2];
    assign flags_rd_clr = rd & port_hit & (idx == pdl_pkg::IDX_EVENT_ENABLE_FLAGS);

    // An event arriving in the cycle of the clearing read survives the read.
    for (genvar i = 0; i < pdl_pkg::NUM_EVENTS; i++)
    begin : g_flag
        assign flags_nxt[i] = PORT_EVENTS[i] | (s_reg.flags[i] & ~flags_rd_clr);
    end

    pdl_cable_tester pdl_cable_tester_inst (
        .clk(CLOCK),
        .rst(RST),
        .start(s_reg.diag_start),
        .abort(s_reg.diag_abort),
        .pair(s_reg.diag_pair),
        .pair_open(PAIR_OPEN),
        .pair_short(PAIR_SHORT),
        .busy(diag_busy),
        .done(diag_done),
        .result(diag_result)
    );

    always_comb
    begin
        logic [15:0] word;
        logic [pdl_pkg::NUM_IRQ-1:0] irq_set;
        logic [pdl_pkg::NUM_IRQ-1:0] irq_w1c;
        logic cnt_full;
        word = 16'h0000;
        irq_set = pdl_pkg::IRQ_RESET;
        irq_w1c = pdl_pkg::IRQ_RESET;
        cnt_full = (s_reg.err_cnt == pdl_pkg::ERR_CNT_MAX);
        s_next = s_reg;
        s_next.ack = access;
        s_next.diag_start = 1'b0;
        s_next.diag_abort = 1'b0;
        s_next.flags = flags_nxt;

        // Read path: data is captured in the cycle the request is taken.
        if (rd)
        begin
            s_next.rdata = pdl_pkg::DATA_ZERO;
            if (port_hit)
            begin
                case (idx)
                    pdl_pkg::IDX_CABLE_DIAG:
                    begin
                        // The pending start pulse also reads as busy.
                        word[pdl_pkg::DIAG_START_BIT] = diag_busy | s_reg.diag_start;
                        word[pdl_pkg::DIAG_RSV_HI_BIT] = s_reg.diag_rsv_hi;
                        word[pdl_pkg::DIAG_PAIR_LSB +: 2] = s_reg.diag_pair;
                        word[pdl_pkg::DIAG_RSV_LO_LSB +: 2] = s_reg.diag_rsv_lo;
                        word[pdl_pkg::DIAG_RESULT_LSB +: 2] = diag_result;
                    end
                    pdl_pkg::IDX_LINK_STATUS:
                    begin
                        word[pdl_pkg::LINK_1000_BIT] = LINK_UP_1000;
                        word[pdl_pkg::LINK_100_BIT] = LINK_UP_100;
                    end
                    pdl_pkg::IDX_RX_SYM_ERR_CNT:
                    begin
                        word = s_reg.err_cnt;
                    end
                    pdl_pkg::IDX_EVENT_ENABLE_FLAGS:
                    begin
                        word[pdl_pkg::ENABLE_LSB +: pdl_pkg::NUM_EVENTS] = s_reg.enables;
                        word[pdl_pkg::FLAG_LSB +: pdl_pkg::NUM_EVENTS] = s_reg.flags;
                    end
                    pdl_pkg::IDX_IRQ_STATUS:
                    begin
                        word[pdl_pkg::NUM_IRQ-1:0] = s_reg.irq_status;
                    end
                    pdl_pkg::IDX_IRQ_MASK:
                    begin
                        word[pdl_pkg::NUM_IRQ-1:0] = s_reg.irq_mask;
                    end
                    default:
                    begin
                        word = 16'h0000;
                    end
                endcase
            end
            s_next.rdata = {16'h0000, word};
        end

        // Write path: byte lane 0 holds bits 7:0, lane 1 bits 15:8.
        if (wr && port_hit)
        begin
            case (idx)
                pdl_pkg::IDX_CABLE_DIAG:
                begin
                    if (SEL_I[1])
                    begin
                        s_next.diag_rsv_hi = DAT_I[pdl_pkg::DIAG_RSV_HI_BIT];
                        s_next.diag_pair = DAT_I[pdl_pkg::DIAG_PAIR_LSB +: 2];
                        s_next.diag_rsv_lo = DAT_I[pdl_pkg::DIAG_RSV_LO_LSB +: 2];
                        s_next.diag_start = DAT_I[pdl_pkg::DIAG_START_BIT];
                        s_next.diag_abort = ~DAT_I[pdl_pkg::DIAG_START_BIT];
                    end
                end
                pdl_pkg::IDX_EVENT_ENABLE_FLAGS:
                begin
                    if (SEL_I[1])
                        s_next.enables = DAT_I[pdl_pkg::ENABLE_LSB +: pdl_pkg::NUM_EVENTS];
                end
                pdl_pkg::IDX_IRQ_STATUS:
                begin
                    if (SEL_I[0])
                        irq_w1c = DAT_I[pdl_pkg::NUM_IRQ-1:0];
                end
                pdl_pkg::IDX_IRQ_MASK:
                begin
                    if (SEL_I[0])
                        s_next.irq_mask = DAT_I[pdl_pkg::NUM_IRQ-1:0];
                end
                default:
                begin
                    s_next.irq_mask = s_reg.irq_mask;
                end
            endcase
        end

        // The counter saturates rather than wrapping, so a full count never reads small.
        if (rd && port_hit && idx == pdl_pkg::IDX_RX_SYM_ERR_CNT)
        begin
            s_next.err_cnt = RX_SYMBOL_ERROR_FRAME ? pdl_pkg::ERR_CNT_ONE
                                                   : pdl_pkg::ERR_CNT_RESET;
        end
        else if (RX_SYMBOL_ERROR_FRAME && !cnt_full)
        begin
            s_next.err_cnt = s_reg.err_cnt + pdl_pkg::ERR_CNT_ONE;
        end

        // Sticky status: a new event wins over a write-one-to-clear in the same cycle.
        irq_set[pdl_pkg::IRQ_DIAG_DONE] = diag_done;
        irq_set[pdl_pkg::IRQ_PORT_EVENT] = |PORT_EVENTS;
        irq_set[pdl_pkg::IRQ_ERR_CNT_FULL] = RX_SYMBOL_ERROR_FRAME & cnt_full;
        s_next.irq_status = (s_reg.irq_status & ~irq_w1c) | irq_set;

        s_next.port_irq = |(s_next.flags & s_next.enables);
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            s_reg.ack <= 1'b0;
            s_reg.rdata <= pdl_pkg::DATA_ZERO;
            s_reg.diag_start <= 1'b0;
            s_reg.diag_abort <= 1'b0;
            s_reg.diag_rsv_hi <= 1'b0;
            s_reg.diag_pair <= pdl_pkg::FIELD2_RESET;
            s_reg.diag_rsv_lo <= pdl_pkg::FIELD2_RESET;
            s_reg.flags <= pdl_pkg::FLAGS_RESET;
            s_reg.enables <= pdl_pkg::ENABLE_RESET;
            s_reg.err_cnt <= pdl_pkg::ERR_CNT_RESET;
            s_reg.irq_status <= pdl_pkg::IRQ_RESET;
            s_reg.irq_mask <= pdl_pkg::IRQ_RESET;
            s_reg.port_irq <= 1'b0;
            s_reg.irq <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign DAT_O = s_reg.rdata;
    assign ACK_O = s_reg.ack;
    assign DIAG_ACTIVE = diag_busy;
    assign DIAG_PAIR = s_reg.diag_pair;
    assign PORT_IRQ = s_reg.port_irq;
    assign IRQ = s_reg.irq;

endmodule

`default_nettype wire

// ==== dv/pdl_regs_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module pdl_regs_assertions #(
    parameter logic [pdl_pkg::PORT_W-1:0] PORT_NUM = pdl_pkg::PORT_NUM_DEFAULT
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [pdl_pkg::ADR_W-1:0] ADR_I,
    input wire logic [pdl_pkg::DAT_W-1:0] DAT_I,
    input wire logic [pdl_pkg::DAT_W-1:0] DAT_O,
    input wire logic WE_I,
    input wire logic [pdl_pkg::SEL_W-1:0] SEL_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic ACK_O,
    input wire logic LINK_UP_1000,
    input wire logic LINK_UP_100,
    input wire logic DIAG_ACTIVE,
    input wire logic [1:0] DIAG_PAIR,
    input wire logic PORT_IRQ,
    input wire logic IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic take;
    logic own;
    logic diag_wr;
    logic [10:0] run_reg;
    logic [10:0] run_next;
    assign take = CYC_I && STB_I && !ACK_O;
    assign own = ADR_I[17:14] == PORT_NUM;
    assign diag_wr = take && WE_I && SEL_I[1] && own && ADR_I[13:2] == pdl_pkg::IDX_CABLE_DIAG;
    // Counts consecutive busy cycles so the test length can be bounded.
    always_comb run_next = DIAG_ACTIVE ? run_reg + 11'h001 : 11'h000;
    always_ff @(posedge CLOCK) run_reg <= RST ? 11'h000 : run_next;
    sequence start_req;
        diag_wr && DAT_I[15] && !DIAG_ACTIVE;
    endsequence
    sequence abort_req;
        diag_wr && !DAT_I[15] && DIAG_ACTIVE;
    endsequence
    a_ack_follows: assert property (take |=> ACK_O) else $error("no ack after request");
    a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack held too long");
    a_ack_caused: assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("stray ack");
    a_reset_quiet: assert property ($fell(RST) |-> !ACK_O && !IRQ && !PORT_IRQ && !DIAG_ACTIVE)
        else $error("outputs active after reset");
    a_upper_zero: assert property (ACK_O |-> DAT_O[31:16] == 16'h0000) else $error("upper half");
    a_link_live: assert property (take && !WE_I && own && ADR_I[13:2] == pdl_pkg::IDX_LINK_STATUS
        |=> DAT_O[15:0] == {14'h0000, $past(LINK_UP_1000), $past(LINK_UP_100)})
        else $error("link status read wrong");
    a_foreign_zero: assert property (take && !WE_I && !own |=> DAT_O == 32'h0000_0000)
        else $error("foreign port read not zero");
    a_diag_starts: assert property (start_req |-> ##[1:3] DIAG_ACTIVE)
        else $error("cable test did not start");
    a_diag_pair: assert property (diag_wr && !DIAG_ACTIVE |-> ##2 DIAG_PAIR == $past(DAT_I[13:12], 2))
        else $error("pair select not applied");
    a_abort_stops: assert property (abort_req |-> ##[1:3] !DIAG_ACTIVE)
        else $error("abort did not stop test");
    a_test_length: assert property (DIAG_ACTIVE |-> run_reg < 11'h3e8)
        else $error("cable test ran too long");
endmodule
bind pdl_regs pdl_regs_assertions #(.PORT_NUM(PORT_NUM)) pdl_regs_assertions_inst (
    .CLOCK(CLOCK), .RST(RST), .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .WE_I(WE_I),
    .SEL_I(SEL_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .LINK_UP_1000(LINK_UP_1000),
    .LINK_UP_100(LINK_UP_100), .DIAG_ACTIVE(DIAG_ACTIVE), .DIAG_PAIR(DIAG_PAIR),
    .PORT_IRQ(PORT_IRQ), .IRQ(IRQ));
`default_nettype wire

// ==== dv/pdl_cable_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
// Cable and remote link partner: link levels, event pulses and comparator levels.
module pdl_cable_partner (
    input wire logic clk,
    output logic link_up_1000,
    output logic link_up_100,
    output logic symbol_error_frame,
    output logic [7:0] events,
    output logic [3:0] pair_open,
    output logic [3:0] pair_short
);
    initial
    begin
        {link_up_1000, link_up_100, symbol_error_frame} = 3'h0;
        events = 8'h00;
        pair_open = 4'h0;
        pair_short = 4'h0;
    end
    task automatic set_link(input logic [1:0] l);
        @(posedge clk);
        {link_up_1000, link_up_100} <= l;
    endtask
    // Events are single-cycle, since a held level would re-set a flag every cycle.
    task automatic pulse(input logic [7:0] ev, input logic err);
        @(posedge clk);
        events <= ev;
        symbol_error_frame <= err;
        @(posedge clk);
        events <= 8'h00;
        symbol_error_frame <= 1'b0;
    endtask
    task automatic set_faults(input logic [3:0] o, input logic [3:0] s);
        @(posedge clk);
        pair_open <= o;
        pair_short <= s;
    endtask
endmodule
`default_nettype wire

// ==== dv/pdl_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module pdl_regs_tb;
    localparam logic [3:0] PORT = 4'h2;
    logic clk, rst, we, cyc, stb, ack, l1000, l100, sef, diag_active, port_irq, irq;
    logic [17:0] adr;
    logic [31:0] dat, rdata;
    logic [3:0] sel, popen, pshort;
    logic [7:0] ev;
    logic [1:0] prev, dpair;
    int err_total, comparisons;
    pdl_cable_partner pdl_cable_partner_inst (.clk(clk), .link_up_1000(l1000),
        .link_up_100(l100), .symbol_error_frame(sef), .events(ev), .pair_open(popen),
        .pair_short(pshort));
    pdl_regs #(.PORT_NUM(PORT)) pdl_regs_inst (.CLOCK(clk), .RST(rst), .ADR_I(adr),
        .DAT_I(dat), .DAT_O(rdata), .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb),
        .ACK_O(ack), .LINK_UP_1000(l1000), .LINK_UP_100(l100), .RX_SYMBOL_ERROR_FRAME(sef),
        .PORT_EVENTS(ev), .PAIR_OPEN(popen), .PAIR_SHORT(pshort), .DIAG_ACTIVE(diag_active),
        .DIAG_PAIR(dpair), .PORT_IRQ(port_irq), .IRQ(irq));
    always #5 clk = ~clk;
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: pin %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] p, input logic [11:0] idx,
        input logic [15:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        {cyc, stb, we, sel} <= {2'b11, w, 4'h3};
        adr <= {p, idx, 2'b00};
        dat <= {16'h0000, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            err_total++;
            summarize();
        end
        q = rdata;
        {cyc, stb, we} <= 3'h0;
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, PORT, idx, 16'h0000, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [11:0] idx, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, PORT, idx, d, q);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    initial
    begin
        logic [31:0] q;
        logic [1:0] res;
        int n;
        {clk, rst, we, cyc, stb} = 5'h01 << 3;
        adr = 18'h0_0000;
        dat = 32'h0000_0000;
        sel = 4'h0;
        prev = 2'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(pdl_pkg::IDX_CABLE_DIAG, 32'h0000_0000);
        rd(pdl_pkg::IDX_RX_SYM_ERR_CNT, 32'h0000_0000);
        rd(pdl_pkg::IDX_EVENT_ENABLE_FLAGS, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            pdl_cable_partner_inst.set_link(2'(i));
            rd(pdl_pkg::IDX_LINK_STATUS, 32'(i));
        end
        repeat (3) pdl_cable_partner_inst.pulse(8'h00, 1'b1);
        rd(pdl_pkg::IDX_RX_SYM_ERR_CNT, 32'h0000_0003);
        rd(pdl_pkg::IDX_RX_SYM_ERR_CNT, 32'h0000_0000);
        for (int i = 0; i < 8; i++)
        begin
            pdl_cable_partner_inst.pulse(8'h01 << i, 1'b0);
            rd(pdl_pkg::IDX_EVENT_ENABLE_FLAGS, 32'h0000_0001 << i);
            rd(pdl_pkg::IDX_EVENT_ENABLE_FLAGS, 32'h0000_0000);
        end
        $display("test status registers done");
        wr(pdl_pkg::IDX_EVENT_ENABLE_FLAGS, 16'h0100);
        pdl_cable_partner_inst.pulse(8'h02, 1'b0);
        settle();
        chk_pin(port_irq, 1'b0);
        pdl_cable_partner_inst.pulse(8'h01, 1'b0);
        settle();
        chk_pin(port_irq, 1'b1);
        rd(pdl_pkg::IDX_EVENT_ENABLE_FLAGS, 32'h0000_0103);
        settle();
        chk_pin(port_irq, 1'b0);
        wr(pdl_pkg::IDX_EVENT_ENABLE_FLAGS, 16'hff00);
        rd(pdl_pkg::IDX_EVENT_ENABLE_FLAGS, 32'h0000_ff00);
        wr(pdl_pkg::IDX_EVENT_ENABLE_FLAGS, 16'h0000);
        $display("test port interrupt done");
        for (int p = 0; p < 4; p++)
        begin
            // Faults on other pairs must not leak into the selected pair's verdict.
            pdl_cable_partner_inst.set_faults(p >= 2 ? 4'h1 << p : 4'hf ^ (4'h1 << p),
                p % 2 == 1 ? 4'h1 << p : 4'h0);
            res = p % 2 == 1 ? pdl_pkg::CABLE_SHORT : p == 2 ? pdl_pkg::CABLE_OPEN
                : pdl_pkg::CABLE_NO_FAULT;
            wr(pdl_pkg::IDX_CABLE_DIAG, {2'b10, 2'(p), 12'h000});
            rd(pdl_pkg::IDX_CABLE_DIAG, {16'h0000, 2'b10, 2'(p), 2'b00, prev, 8'h00});
            chk(32'(dpair), 32'(p));
            n = 0;
            while (diag_active === 1'b1 && n < 1100)
            begin
                @(posedge clk);
                n++;
            end
            chk_pin(diag_active, 1'b0);
            // A test that never ends has already been counted; stop waiting on it.
            if (diag_active === 1'b1)
                summarize();
            rd(pdl_pkg::IDX_CABLE_DIAG, {16'h0000, 2'b00, 2'(p), 2'b00, res, 8'h00});
            prev = res;
            settle();
            chk_pin(irq, p != 0);
            if (p == 0)
                wr(pdl_pkg::IDX_IRQ_MASK, 16'h0001);
            settle();
            chk_pin(irq, 1'b1);
            wr(pdl_pkg::IDX_IRQ_STATUS, 16'h0001);
            settle();
            chk_pin(irq, 1'b0);
        end
        // Port events earlier in the run left the sticky event bit set; done was cleared.
        rd(pdl_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
        rd(pdl_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        $display("test cable pairs done");
        wr(pdl_pkg::IDX_CABLE_DIAG, 16'h8000);
        settle();
        chk_pin(diag_active, 1'b1);
        wr(pdl_pkg::IDX_CABLE_DIAG, 16'h0000);
        settle();
        chk_pin(diag_active, 1'b0);
        rd(pdl_pkg::IDX_CABLE_DIAG, 32'(prev) << 8);
        $display("test abort done");
        wb(1'b0, 4'h1, pdl_pkg::IDX_LINK_STATUS, 16'h0000, q);
        chk(q, 32'h0000_0000);
        rd(12'h200, 32'h0000_0000);
        $display("test unmapped done");
        summarize();
    end
endmodule
`default_nettype wire
